// ===== sfr_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides and a flush
`timescale 1ns/100ps
module sfr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             sys_clk_in,
	input  wire logic             rst_in,
	input  wire logic             flush_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  out_valid_out,
	output logic      [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [PW-1:0]    wr_ptr_ff;
	logic [PW-1:0]    rd_ptr_ff;
	logic [PW:0]      count_ff;
	logic             push;
	logic             pop;

	assign in_ready_out  = (count_ff != (PW+1)'(DEPTH));
	assign out_valid_out = (count_ff != '0);
	assign out_data_out  = mem_ff[rd_ptr_ff];
	assign push          = in_valid_in && in_ready_out && !flush_in;
	assign pop           = out_valid_out && out_ready_in && !flush_in;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == (PW)'(DEPTH-1)) ? '0 : p + 1'b1;
	endfunction : ptr_inc

	always_ff @(posedge sys_clk_in) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data_in;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in || flush_in) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= ptr_inc(wr_ptr_ff);
			end
			if (pop) begin
				rd_ptr_ff <= ptr_inc(rd_ptr_ff);
			end
			count_ff <= count_ff + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

endmodule : sfr_fifo

// ===== sfr_host_model.sv
// Host model: chip select, serial clock and command bits; samples the data lanes
`timescale 1ns/100ps
module sfr_host_model (
	input  wire logic sys_clk_in,
	input  wire logic lane_0_in,
	input  wire logic lane_1_in,
	input  wire logic lane_2_in,
	input  wire logic lane_3_in,
	output logic      cs_n_out,
	output logic      sclk_out,
	output logic      si_out
);
	// Serial clock idles low between frames
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		si_out   = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask : tick

	// 12 + 13 system clocks give the 125 ns serial clock; lanes taken at the rise
	task automatic bit_clk(input logic b, output logic [3:0] q);
		si_out <= b;
		tick(12);
		sclk_out <= 1'b1;
		q = {lane_3_in, lane_2_in, lane_1_in, lane_0_in};
		tick(13);
		sclk_out <= 1'b0;
	endtask : bit_clk

	// Past the address the serial line toggles each clock, as a floating line may
	task automatic frame(input logic [7:0] op, input logic [31:0] addr, input int nab,
			input int ndum, input int ln, input int nbytes, output logic [63:0] got);
		logic [3:0] q;
		int         k;
		got = 64'h0;
		tick(1);
		cs_n_out <= 1'b0;
		for (k = 7; k >= 0; k--) bit_clk(op[k], q);
		for (k = nab - 1; k >= 0; k--) bit_clk(addr[k], q);
		for (k = 0; k < ndum; k++) bit_clk(~si_out, q);
		for (k = 0; k < nbytes * 8 / ln; k++) begin
			bit_clk(~si_out, q);
			got = (ln == 4) ? {got[59:0], q} : (ln == 2) ? {got[61:0], q[1:0]} : {got[62:0], q[1]};
		end
		tick(12);
		cs_n_out <= 1'b1;
		tick(12);
	endtask : frame
endmodule : sfr_host_model

// ===== sfr_pkg.sv
// Package: opcodes, phase encoding and reset values for the serial flash read block
package sfr_pkg;

	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_READ      = 8'h03;
	localparam logic [7:0] OPC_READ_4B   = 8'h13;
	localparam logic [7:0] OPC_FAST      = 8'h0B;
	localparam logic [7:0] OPC_FAST_4B   = 8'h0C;
	localparam logic [7:0] OPC_DUAL      = 8'h3B;
	localparam logic [7:0] OPC_DUAL_4B   = 8'h3C;
	localparam logic [7:0] OPC_QUAD      = 8'h6B;
	localparam logic [7:0] OPC_ENTER_4B  = 8'hB7;
	localparam logic [7:0] OPC_EXIT_4B   = 8'hE9;

	// ----------------------------------------------------------------
	// Field sizes, counts and reset values
	// ----------------------------------------------------------------
	localparam logic [5:0] OPC_BITS      = 6'h08;
	localparam logic [5:0] ADDR_BITS_3B  = 6'h18;
	localparam logic [5:0] ADDR_BITS_4B  = 6'h20;
	localparam logic [5:0] DUMMY_CLOCKS  = 6'h08;
	localparam logic [3:0] BYTE_BITS     = 4'h8;
	localparam logic [7:0] EXT_ADDR_RST  = 8'h00;
	localparam logic       ADS_RST       = 1'b0;
	localparam int         FIFO_DEPTH    = 4;

	// Lane counts of the data phase
	localparam logic [2:0] LANES_1       = 3'h1;
	localparam logic [2:0] LANES_2       = 3'h2;
	localparam logic [2:0] LANES_4       = 3'h4;

	// ----------------------------------------------------------------
	// Frame phases, Gray along opcode, address, dummy, data
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PH_IDLE   = 3'b000,
		PH_OPC    = 3'b001,
		PH_ADDR   = 3'b011,
		PH_DUMMY  = 3'b010,
		PH_DATA   = 3'b110,
		PH_IGNORE = 3'b100
	} sfr_phase_t;

endpackage : sfr_pkg

// ===== sfr_read_cmd.sv
// Device-side read command engine of a serial NOR flash, sampled on the system clock
`timescale 1ns/100ps

module sfr_read_cmd
	import sfr_pkg::*;
#(
	parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic        sw_reset_in,
	input  wire logic        cs_n_in,
	input  wire logic        sclk_in,
	input  wire logic        data_line_0_in,
	input  wire logic        busy_in,
	input  wire logic        quad_enable_bit_in,
	input  wire logic        std_spi_mode_in,
	input  wire logic        ext_addr_wr_in,
	input  wire logic [7:0]  ext_addr_wdata_in,
	output logic             data_line_0_out,
	output logic             data_line_0_oe_out,
	output logic             data_line_1_out,
	output logic             data_line_1_oe_out,
	output logic             data_line_2_out,
	output logic             data_line_2_oe_out,
	output logic             data_line_3_out,
	output logic             data_line_3_oe_out,
	output logic             mem_rd_out,
	output logic [31:0]      mem_addr_out,
	input  wire logic        mem_data_valid_in,
	input  wire logic [7:0]  mem_data_in,
	output logic             address_size_mode_bit_out,
	output logic [7:0]       ext_addr_out,
	output logic             cmd_active_out,
	output logic             cmd_ignored_out,
	output logic             underrun_out
);

	// ----------------------------------------------------------------
	// Pin synchronisers and clock edge detection
	// ----------------------------------------------------------------
	logic [2:0] pins_sync;
	logic       cs_n_s;
	logic       sclk_s;
	logic       si_s;
	logic       sclk_prev_ff;
	logic       rise;
	logic       fall;

	sfr_sync #(
		.WIDTH (3)
	) u_sync (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.async_in   ({cs_n_in, sclk_in, data_line_0_in}),
		.rst_val_in (3'h4),
		.sync_out   (pins_sync)
	);

	assign cs_n_s = pins_sync[2];
	assign sclk_s = pins_sync[1];
	assign si_s   = pins_sync[0];

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			sclk_prev_ff <= 1'b0;
		end else begin
			sclk_prev_ff <= sclk_s;
		end
	end

	// Edges only count inside a frame; the clock may idle either way between frames
	assign rise = !cs_n_s && sclk_s && !sclk_prev_ff;
	assign fall = !cs_n_s && !sclk_s && sclk_prev_ff;

	// ----------------------------------------------------------------
	// Opcode decode
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       is_read;
		logic       needs_spi;
		logic       needs_qe;
		logic       force_4b;
		logic       has_dummy;
		logic [2:0] lanes;
	} sfr_dec_t;

	function automatic sfr_dec_t sfr_decode(input logic [7:0] opc);
		sfr_dec_t d;
		d = '0;
		d.lanes = LANES_1;
		unique case (opc)
			OPC_READ: begin
				d.is_read = 1'b1;
				d.needs_spi = 1'b1;
			end
			OPC_READ_4B: begin
				d.is_read = 1'b1;
				d.needs_spi = 1'b1;
				d.force_4b = 1'b1;
			end
			OPC_FAST: begin
				d.is_read = 1'b1;
				d.has_dummy = 1'b1;
			end
			OPC_FAST_4B: begin
				d.is_read = 1'b1;
				d.needs_spi = 1'b1;
				d.force_4b = 1'b1;
				d.has_dummy = 1'b1;
			end
			OPC_DUAL: begin
				d.is_read = 1'b1;
				d.has_dummy = 1'b1;
				d.lanes = LANES_2;
			end
			OPC_DUAL_4B: begin
				d.is_read = 1'b1;
				d.needs_spi = 1'b1;
				d.force_4b = 1'b1;
				d.has_dummy = 1'b1;
				d.lanes = LANES_2;
			end
			OPC_QUAD: begin
				d.is_read = 1'b1;
				d.needs_qe = 1'b1;
				d.has_dummy = 1'b1;
				d.lanes = LANES_4;
			end
			default: begin
				d.is_read = 1'b0;
			end
		endcase
		return d;
	endfunction : sfr_decode

	// ----------------------------------------------------------------
	// Frame state
	// ----------------------------------------------------------------
	sfr_phase_t phase_ff;
	sfr_phase_t nxt_phase;
	logic [7:0] opc_ff;
	logic [5:0] bit_cnt_ff;
	logic [5:0] addr_len_ff;
	logic       has_dummy_ff;
	logic [2:0] lanes_ff;
	logic [31:0] addr_sr_ff;
	logic       cs_prev_ff;
	logic       frame_end;
	sfr_dec_t   dec;
	logic [7:0] opc_next;
	logic       accept;
	logic       addr_done;
	logic [31:0] addr_full;

	assign opc_next  = {opc_ff[6:0], si_s};
	assign dec       = sfr_decode(opc_next);
	assign frame_end = cs_n_s && !cs_prev_ff;
	// Reject reads while busy, in the wrong bus mode or without quad enable
	assign accept    = dec.is_read && !busy_in && (!dec.needs_spi || std_spi_mode_in)
		&& (!dec.needs_qe || quad_enable_bit_in);
	assign addr_done = (phase_ff == PH_ADDR) && rise && (bit_cnt_ff == addr_len_ff - 6'h01);
	// Three-byte mode completes the address with the extended register
	assign addr_full = (addr_len_ff == ADDR_BITS_3B) ?
		{ext_addr_out, addr_sr_ff[22:0], si_s} : {addr_sr_ff[30:0], si_s};

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			cs_prev_ff <= 1'b1;
		end else begin
			cs_prev_ff <= cs_n_s;
		end
	end

	always_comb begin
		nxt_phase = phase_ff;
		if (cs_n_s) begin
			nxt_phase = PH_IDLE;
		end else begin
			unique case (phase_ff)
				PH_IDLE: begin
					nxt_phase = PH_OPC;
				end
				PH_OPC: begin
					if (rise && bit_cnt_ff == OPC_BITS - 6'h01) begin
						nxt_phase = accept ? PH_ADDR : PH_IGNORE;
					end
				end
				PH_ADDR: begin
					if (addr_done) begin
						nxt_phase = has_dummy_ff ? PH_DUMMY : PH_DATA;
					end
				end
				PH_DUMMY: begin
					if (rise && bit_cnt_ff == DUMMY_CLOCKS - 6'h01) begin
						nxt_phase = PH_DATA;
					end
				end
				PH_DATA: begin
					nxt_phase = PH_DATA;
				end
				PH_IGNORE: begin
					nxt_phase = PH_IGNORE;
				end
				default: begin
					nxt_phase = PH_IGNORE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			phase_ff <= PH_IDLE;
		end else begin
			phase_ff <= nxt_phase;
		end
	end

	// Bit counter, opcode and address shifters, MSB first on rising edges
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || phase_ff == PH_IDLE) begin
			bit_cnt_ff   <= '0;
			opc_ff       <= '0;
			addr_sr_ff   <= '0;
			addr_len_ff  <= ADDR_BITS_3B;
			has_dummy_ff <= 1'b0;
			lanes_ff     <= LANES_1;
		end else if (rise) begin
			if (nxt_phase != phase_ff) begin
				bit_cnt_ff <= '0;
			end else if (bit_cnt_ff != 6'h3F) begin
				bit_cnt_ff <= bit_cnt_ff + 6'h01;
			end
			if (phase_ff == PH_OPC) begin
				opc_ff <= opc_next;
				if (bit_cnt_ff == OPC_BITS - 6'h01) begin
					addr_len_ff  <= (dec.force_4b || address_size_mode_bit_out) ?
						ADDR_BITS_4B : ADDR_BITS_3B;
					has_dummy_ff <= dec.has_dummy;
					lanes_ff     <= dec.lanes;
				end
			end
			if (phase_ff == PH_ADDR) begin
				addr_sr_ff <= {addr_sr_ff[30:0], si_s};
			end
		end
	end

	// ----------------------------------------------------------------
	// Address mode and extended address register
	// ----------------------------------------------------------------
	logic lone_opc;

	// Mode commands count only if exactly eight bits came before chip select rose
	assign lone_opc = frame_end && phase_ff == PH_IGNORE && bit_cnt_ff == 6'h00;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in || sw_reset_in) begin
			address_size_mode_bit_out <= ADS_RST;
		end else if (lone_opc && opc_ff == OPC_EXIT_4B) begin
			address_size_mode_bit_out <= 1'b0;
		end else if (lone_opc && opc_ff == OPC_ENTER_4B) begin
			address_size_mode_bit_out <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in || sw_reset_in) begin
			ext_addr_out <= EXT_ADDR_RST;
		end else if (addr_done && address_size_mode_bit_out && addr_len_ff == ADDR_BITS_4B) begin
			ext_addr_out <= addr_full[31:24];
		end else if (ext_addr_wr_in) begin
			ext_addr_out <= ext_addr_wdata_in;
		end
	end

	// ----------------------------------------------------------------
	// Array fetch into the prefetch FIFO
	// ----------------------------------------------------------------
	logic       fetch_en_ff;
	logic       pend_ff;
	logic       fifo_in_ready;
	logic       fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic       fifo_pop;
	logic       byte_load;

	// One request in flight at a time; a full FIFO stalls further requests
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			fetch_en_ff  <= 1'b0;
			pend_ff      <= 1'b0;
			mem_rd_out   <= 1'b0;
			mem_addr_out <= '0;
		end else begin
			mem_rd_out <= 1'b0;
			if (cs_n_s) begin
				fetch_en_ff <= 1'b0;
			end else if (addr_done) begin
				fetch_en_ff  <= 1'b1;
				mem_addr_out <= addr_full;
			end
			if (mem_data_valid_in) begin
				pend_ff <= 1'b0;
			end else if (fetch_en_ff && !cs_n_s && !pend_ff && fifo_in_ready) begin
				pend_ff    <= 1'b1;
				mem_rd_out <= 1'b1;
			end
			if (mem_rd_out) begin
				mem_addr_out <= mem_addr_out + 32'h0000_0001;
			end
		end
	end

	sfr_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH_P)
	) u_fifo (
		.sys_clk_in    (sys_clk_in),
		.rst_in        (rst_in),
		.flush_in      (!fetch_en_ff),
		.in_valid_in   (mem_data_valid_in),
		.in_data_in    (mem_data_in),
		.in_ready_out  (fifo_in_ready),
		.out_valid_out (fifo_out_valid),
		.out_data_out  (fifo_out_data),
		.out_ready_in  (fifo_pop)
	);

	// ----------------------------------------------------------------
	// Output shifter, updated on falling edges
	// ----------------------------------------------------------------
	logic [7:0] out_sr_ff;
	logic [3:0] bits_left_ff;
	logic [7:0] shifted;

	assign byte_load = (phase_ff == PH_DATA) && fall && bits_left_ff == 4'h0;
	assign fifo_pop  = byte_load;
	assign shifted   = byte_load ? fifo_out_data : (out_sr_ff << lanes_ff);

	always_ff @(posedge sys_clk_in) begin
		if (rst_in || phase_ff != PH_DATA) begin
			out_sr_ff    <= '0;
			bits_left_ff <= '0;
		end else if (fall) begin
			out_sr_ff    <= shifted;
			bits_left_ff <= (byte_load ? BYTE_BITS : bits_left_ff) - {1'b0, lanes_ff};
		end
	end

	// Lane mapping: single on line 1, dual on 1..0, quad on 3..0, MSB on the highest line
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || phase_ff != PH_DATA) begin
			data_line_0_out <= 1'b0;
			data_line_1_out <= 1'b0;
			data_line_2_out <= 1'b0;
			data_line_3_out <= 1'b0;
		end else if (fall) begin
			unique case (lanes_ff)
				LANES_2: begin
					data_line_1_out <= shifted[7];
					data_line_0_out <= shifted[6];
				end
				LANES_4: begin
					data_line_3_out <= shifted[7];
					data_line_2_out <= shifted[6];
					data_line_1_out <= shifted[5];
					data_line_0_out <= shifted[4];
				end
				default: begin
					data_line_1_out <= shifted[7];
				end
			endcase
		end
	end

	// Enables rise with the first data fall, so the dummy phase stays floating
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || phase_ff != PH_DATA) begin
			data_line_0_oe_out <= 1'b0;
			data_line_1_oe_out <= 1'b0;
			data_line_2_oe_out <= 1'b0;
			data_line_3_oe_out <= 1'b0;
		end else if (fall) begin
			data_line_1_oe_out <= 1'b1;
			data_line_0_oe_out <= lanes_ff != LANES_1;
			data_line_2_oe_out <= lanes_ff == LANES_4;
			data_line_3_oe_out <= lanes_ff == LANES_4;
		end
	end

	// ----------------------------------------------------------------
	// Status
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			cmd_active_out  <= 1'b0;
			cmd_ignored_out <= 1'b0;
			underrun_out    <= 1'b0;
		end else begin
			cmd_active_out  <= (nxt_phase == PH_ADDR) || (nxt_phase == PH_DUMMY) || (nxt_phase == PH_DATA);
			// Held from the opcode's last bit; the decode follows the live data line after it
			cmd_ignored_out <= (nxt_phase == PH_IGNORE)
				&& ((phase_ff == PH_IGNORE) ? cmd_ignored_out : dec.is_read);
			// Sticky per frame; the array was too slow for the serial clock
			if (phase_ff == PH_IDLE) begin
				underrun_out <= 1'b0;
			end else if (byte_load && !fifo_out_valid) begin
				underrun_out <= 1'b1;
			end
		end
	end

endmodule : sfr_read_cmd

// ===== sfr_read_cmd_props.sv
// Checker: port-level properties of the serial flash read engine
`timescale 1ns/100ps
module sfr_read_cmd_props #(
	parameter int FIFO_DEPTH_P = 4
) (
	input wire logic        sys_clk_in,
	input wire logic        rst_in,
	input wire logic        sw_reset_in,
	input wire logic        cs_n_in,
	input wire logic        busy_in,
	input wire logic        quad_enable_bit_in,
	input wire logic        ext_addr_wr_in,
	input wire logic [7:0]  ext_addr_wdata_in,
	input wire logic        data_line_0_oe_out,
	input wire logic        data_line_1_oe_out,
	input wire logic        data_line_2_oe_out,
	input wire logic        data_line_3_oe_out,
	input wire logic        mem_rd_out,
	input wire logic [31:0] mem_addr_out,
	input wire logic        address_size_mode_bit_out,
	input wire logic [7:0]  ext_addr_out,
	input wire logic        cmd_active_out,
	input wire logic        cmd_ignored_out
);
	logic any_oe;

	assign any_oe = data_line_0_oe_out | data_line_1_oe_out | data_line_2_oe_out | data_line_3_oe_out;

	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);

	// ----
	// Sequences
	// ----
	// Eight samples cover the synchroniser and the output register
	sequence s_cs_idle;
		cs_n_in [*8];
	endsequence
	sequence s_rd_step;
		mem_rd_out ##1 (!mem_rd_out && mem_addr_out == $past(mem_addr_out) + 32'h1);
	endsequence

	// ----
	// Assertions
	// ----
	a_oe_idle_cs: assert property (s_cs_idle |-> !any_oe)
		else $error("data line driven outside frame");
	a_refused_quiet: assert property (cmd_ignored_out |-> !any_oe && !mem_rd_out)
		else $error("refused read drives or fetches");
	a_accept_excl: assert property (!(cmd_active_out && cmd_ignored_out))
		else $error("read both accepted and refused");
	a_rd_addr_step: assert property (mem_rd_out |-> s_rd_step)
		else $error("array request not one cycle or address not advanced");
	a_reset_clears: assert property (disable iff (1'b0) rst_in |=>
		ext_addr_out == 8'h00 && !address_size_mode_bit_out && !any_oe)
		else $error("reset left mode, extended byte or drive");
	a_swreset_clears: assert property (sw_reset_in |=> ext_addr_out == 8'h00 && !address_size_mode_bit_out)
		else $error("soft reset left mode or extended byte");
	a_ext_write: assert property (ext_addr_wr_in && cs_n_in && !sw_reset_in |=>
		ext_addr_out == $past(ext_addr_wdata_in))
		else $error("extended byte not written");
	a_mode_frame: assert property (cmd_active_out |=> $stable(address_size_mode_bit_out))
		else $error("address mode changed inside a read");
	a_quad_needs_qe: assert property (data_line_3_oe_out |-> quad_enable_bit_in && data_line_2_oe_out)
		else $error("quad lanes driven without quad enable");
	a_dual_lanes: assert property (data_line_0_oe_out |-> data_line_1_oe_out)
		else $error("line zero driven without line one");
	a_busy_refuse: assert property ($rose(cmd_active_out) |-> !$past(busy_in))
		else $error("read accepted while array busy");
endmodule : sfr_read_cmd_props

bind sfr_read_cmd sfr_read_cmd_props #(.FIFO_DEPTH_P(FIFO_DEPTH_P)) i_props (
	.sys_clk_in(sys_clk_in), .rst_in(rst_in), .sw_reset_in(sw_reset_in), .cs_n_in(cs_n_in),
	.quad_enable_bit_in(quad_enable_bit_in), .ext_addr_wr_in(ext_addr_wr_in), .busy_in(busy_in),
	.ext_addr_wdata_in(ext_addr_wdata_in), .data_line_0_oe_out(data_line_0_oe_out),
	.data_line_1_oe_out(data_line_1_oe_out), .data_line_2_oe_out(data_line_2_oe_out),
	.data_line_3_oe_out(data_line_3_oe_out), .mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out),
	.address_size_mode_bit_out(address_size_mode_bit_out), .ext_addr_out(ext_addr_out),
	.cmd_active_out(cmd_active_out), .cmd_ignored_out(cmd_ignored_out)
);

// ===== sfr_sync.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
module sfr_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk_in,
	input  wire logic             rst_in,
	input  wire logic [WIDTH-1:0] async_in,
	input  wire logic [WIDTH-1:0] rst_val_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;

	// Reset value is a constant at every instance; outside reset only meta_ff feeds sync_out
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			meta_ff  <= rst_val_in;
			sync_out <= rst_val_in;
		end else begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end

endmodule : sfr_sync

// ===== tb_serial_flash_read_commands.sv
// Testbench: read engine against the host model and a two-cycle array model
`timescale 1ns/100ps
module tb_serial_flash_read_commands
	import sfr_pkg::*;
;
	logic        sys_clk = 1'b0, rst = 1'b1, sw_rst = 1'b0, busy = 1'b0, qe = 1'b1, std_spi = 1'b1;
	logic        ext_wr = 1'b0, mem_valid = 1'b0, rd_dly = 1'b0, clr = 1'b1, saw_ign, saw_oe, saw_rd, saw_urun;
	logic [7:0]  ext_wdata = 8'h00, mem_data = 8'h00;
	logic [31:0] req_addr;
	logic [63:0] got;
	wire         cs_n, sclk, si, d0, mem_rd, address_size_mode_bit, act, ign, urun;
	wire  [3:0]  dout, doe;
	wire  [7:0]  ext;
	wire  [31:0] mem_addr;
	int          errors = 0, checks_done = 0, i;
	logic [7:0]  ops [7] = '{OPC_READ, OPC_READ_4B, OPC_FAST, OPC_FAST_4B, OPC_DUAL, OPC_DUAL_4B, OPC_QUAD};
	int          nabs [7] = '{24, 32, 24, 32, 24, 32, 24};
	int          dums [7] = '{0, 0, 8, 8, 8, 8, 8};
	int          lns [7] = '{1, 1, 1, 1, 2, 2, 4};
	logic [7:0]  bad_op [7] = '{OPC_READ, OPC_READ_4B, OPC_READ, OPC_READ_4B, OPC_FAST_4B, OPC_DUAL_4B, OPC_QUAD};
	logic [6:0]  busy_row = 7'h03, std_row = 7'h43, qe_row = 7'h3F;

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	// The host floats line zero whenever the device drives it
	assign d0 = doe[0] ? dout[0] : si;

	sfr_read_cmd #(.FIFO_DEPTH_P(FIFO_DEPTH)) i_dut (
		.sys_clk_in(sys_clk), .rst_in(rst), .sw_reset_in(sw_rst), .cs_n_in(cs_n), .sclk_in(sclk),
		.data_line_0_in(d0), .busy_in(busy), .quad_enable_bit_in(qe), .std_spi_mode_in(std_spi),
		.ext_addr_wr_in(ext_wr), .ext_addr_wdata_in(ext_wdata), .data_line_0_out(dout[0]),
		.data_line_0_oe_out(doe[0]), .data_line_1_out(dout[1]), .data_line_1_oe_out(doe[1]),
		.data_line_2_out(dout[2]), .data_line_2_oe_out(doe[2]), .data_line_3_out(dout[3]),
		.data_line_3_oe_out(doe[3]), .mem_rd_out(mem_rd), .mem_addr_out(mem_addr),
		.mem_data_valid_in(mem_valid), .mem_data_in(mem_data), .address_size_mode_bit_out(address_size_mode_bit),
		.ext_addr_out(ext), .cmd_active_out(act), .cmd_ignored_out(ign), .underrun_out(urun)
	);

	sfr_host_model i_host (
		.sys_clk_in(sys_clk), .lane_0_in(d0), .lane_1_in(doe[1] ? dout[1] : 1'bz),
		.lane_2_in(doe[2] ? dout[2] : 1'bz), .lane_3_in(doe[3] ? dout[3] : 1'bz),
		.cs_n_out(cs_n), .sclk_out(sclk), .si_out(si)
	);

	function automatic logic [7:0] pat(input logic [31:0] a);
		return a[7:0] ^ a[31:24] ^ 8'hA5;
	endfunction : pat

	function automatic logic [63:0] expect5(input logic [31:0] a);
		logic [63:0] e;
		e = 64'h0;
		for (int n = 0; n < 5; n++) e = {e[55:0], pat(a + n)};
		return e;
	endfunction : expect5

	// Array answers two cycles after each request; frame flags are sticky until cleared
	always @(posedge sys_clk) begin
		rd_dly <= mem_rd;
		mem_valid <= rd_dly;
		if (mem_rd) begin
			req_addr <= mem_addr;
		end
		mem_data <= pat(req_addr);
		if (clr) begin
			{saw_ign, saw_oe, saw_rd, saw_urun} <= 4'h0;
		end else begin
			{saw_ign, saw_oe, saw_rd, saw_urun} <= {saw_ign | ign, saw_oe | (|doe), saw_rd | mem_rd,
				saw_urun | urun};
		end
	end

	task automatic wrap_up();
		$display("errors %0d, checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	task automatic check(input logic [63:0] g, input logic [63:0] e, input string what);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, g, e);
		end
	endtask : check

	// Five bytes read; ex is {refused, drove lanes, fetched}
	task automatic run(input logic [7:0] op, input logic [31:0] a, input int nab, input int dum,
			input int ln, input logic [31:0] ea, input logic [2:0] ex);
		clr <= 1'b1;
		@(posedge sys_clk);
		clr <= 1'b0;
		i_host.frame(op, a, nab, dum, ln, 5, got);
		check({61'h0, saw_ign, saw_oe, saw_rd}, {61'h0, ex}, "frame flags");
		check({63'h0, saw_urun}, 64'h0, "byte underrun");
		if (ex == 3'h3) begin
			check(got, expect5(ea), "read data");
		end
	endtask : run

	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		check({51'h0, address_size_mode_bit, ext, doe}, 64'h0, "reset state");
		ext_wr <= 1'b1;
		ext_wdata <= 8'h12;
		@(posedge sys_clk);
		ext_wr <= 1'b0;
		for (i = 0; i < 7; i++) begin
			run(ops[i], 32'hAB3F_FFFE, nabs[i], dums[i], lns[i],
				(nabs[i] == 32) ? 32'hAB3F_FFFE : 32'h123F_FFFE, 3'h3);
		end
		for (i = 0; i < 7; i++) begin
			busy <= busy_row[i];
			std_spi <= std_row[i];
			qe <= qe_row[i];
			run(bad_op[i], 32'h0, 24, 0, 1, 32'h0, 3'h4);
		end
		busy <= 1'b0;
		std_spi <= 1'b1;
		qe <= 1'b1;
		i_host.frame(OPC_ENTER_4B, 32'h0, 0, 0, 1, 0, got);
		check({63'h0, address_size_mode_bit}, 64'h1, "four-byte mode");
		run(OPC_READ, 32'h3400_0010, 32, 0, 1, 32'h3400_0010, 3'h3);
		check({56'h0, ext}, 64'h34, "upper byte kept");
		i_host.frame(OPC_EXIT_4B, 32'h0, 0, 0, 1, 0, got);
		check({63'h0, address_size_mode_bit}, 64'h0, "three-byte mode");
		run(OPC_READ, 32'h0000_0020, 24, 0, 1, 32'h3400_0020, 3'h3);
		i_host.frame(OPC_ENTER_4B, 32'h0, 0, 0, 1, 0, got);
		check({63'h0, address_size_mode_bit}, 64'h1, "four-byte mode again");
		sw_rst <= 1'b1;
		@(posedge sys_clk);
		sw_rst <= 1'b0;
		@(posedge sys_clk);
		check({55'h0, address_size_mode_bit, ext}, 64'h0, "soft reset");
		wrap_up();
	end

	initial begin
		repeat (90000) @(posedge sys_clk);
		errors++;
		$display("MISMATCH at %0t: run did not finish", $time);
		wrap_up();
	end
endmodule : tb_serial_flash_read_commands
